// file: logic/antijam_bank_ctrl.sv
module antijam_bank_ctrl
  import antijam_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_srst,
  input  wire antijam_cfg_s i_cfg,
  input  wire logic         i_antijam_request,
  output motor_cmd_s        o_motor_cmd,
  output logic              o_sequence_active,
  output logic              o_limit_reached,
  output logic [2:0]        o_consecutive_count,
  input  wire source_e      i_bank_select_source,
  input  wire logic         i_digital_input_n,
  input  wire logic         i_command_word_bit,
  input  wire usage_e       i_usage,
  input  wire logic         i_accel_start,
  input  wire logic         i_decel_start,
  input  wire accel_set_s   i_bank1_accel,
  input  wire decel_set_s   i_bank1_decel,
  input  wire accel_set_s   i_bank2_accel,
  input  wire decel_set_s   i_bank2_decel,
  input  wire logic [1:0]   i_basic_stop_type,
  output accel_set_s        o_active_accel,
  output decel_set_s        o_active_decel,
  output logic              o_bank2_selected
);

  // ----------------------------------------------------------------
  // Slow tick
  // ----------------------------------------------------------------
  logic [27:0] prescale_q;
  logic        tick_q;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      prescale_q <= '0;
      tick_q     <= 1'b0;
    end else if (prescale_q == 28'(TICK_CYCLES - 1)) begin
      prescale_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      prescale_q <= prescale_q + 28'h1;
      tick_q     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Anti-jam sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_FWD, S_PAUSE_F, S_REV, S_PAUSE_R} seq_e;

  seq_e        state_q;
  logic [3:0]  cycles_done_q;
  logic        step_load;
  logic [11:0] step_value;
  logic        step_done;
  logic        start_ok;
  logic        win_load;
  logic        win_done;
  logic [2:0]  consec_q;
  logic        limit_q;
  logic        monitor_on;

  assign monitor_on = (i_cfg.consecutive_window != 12'h000);
  assign start_ok   = i_antijam_request && (state_q == S_IDLE)
                      && !(monitor_on && limit_q);

  always_comb begin
    step_load  = 1'b0;
    step_value = '0;
    case (state_q)
      S_IDLE: begin
        step_load  = start_ok;
        step_value = 12'(i_cfg.forward_duration);
      end
      S_FWD: begin
        step_load  = step_done;
        step_value = 12'(i_cfg.pause_time);
      end
      S_PAUSE_F: begin
        step_load  = step_done;
        step_value = 12'(i_cfg.reverse_duration);
      end
      S_REV: begin
        step_load  = step_done;
        step_value = 12'(i_cfg.pause_time);
      end
      S_PAUSE_R: begin
        step_load  = step_done && (cycles_done_q + 4'h1 < i_cfg.cycle_count);
        step_value = 12'(i_cfg.forward_duration);
      end
      default: begin
        step_load  = 1'b0;
        step_value = '0;
      end
    endcase
  end

  sec_timer #(.W(12)) u_step_timer (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_tick     (tick_q),
    .i_load     (step_load),
    .i_value    (step_value),
    .o_done     (step_done),
    .o_count    ()
  );

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q       <= S_IDLE;
      cycles_done_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          cycles_done_q <= '0;
          if (start_ok) state_q <= S_FWD;
        end
        S_FWD:     if (step_done) state_q <= S_PAUSE_F;
        S_PAUSE_F: if (step_done) state_q <= S_REV;
        S_REV:     if (step_done) state_q <= S_PAUSE_R;
        S_PAUSE_R: begin
          if (step_done) begin
            if (cycles_done_q + 4'h1 >= i_cfg.cycle_count) begin
              state_q <= S_IDLE;
            end else begin
              cycles_done_q <= cycles_done_q + 4'h1;
              state_q       <= S_FWD;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Motor command: step force preset, halt style only honoured with profile
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_motor_cmd <= '{1'b0, 1'b0, FORCE_LOW, 1'b0};
    end else begin
      o_motor_cmd.run_fwd <= (state_q == S_FWD);
      o_motor_cmd.run_rev <= (state_q == S_REV);
      o_motor_cmd.drive_force <= (state_q == S_REV || state_q == S_PAUSE_F)
                                 ? i_cfg.reverse_force : i_cfg.forward_force;
      // Stop style after each step: decel only for profile force
      o_motor_cmd.decel_stop <= (i_cfg.halt_style == HALT_DECEL)
          && (((state_q == S_PAUSE_F) && i_cfg.forward_force == FORCE_PROFILE)
           || ((state_q == S_PAUSE_R) && i_cfg.reverse_force == FORCE_PROFILE));
    end
  end

  // ----------------------------------------------------------------
  // Consecutive sequence monitor
  // ----------------------------------------------------------------
  assign win_load = start_ok;

  sec_timer #(.W(12)) u_window_timer (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_tick     (tick_q),
    .i_load     (win_load),
    .i_value    (i_cfg.consecutive_window),
    .o_done     (win_done),
    .o_count    ()
  );

  // Window restarts at each sequence start; count resets when it lapses
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      consec_q <= '0;
      limit_q  <= 1'b0;
    end else if (!monitor_on) begin
      consec_q <= '0;
      limit_q  <= 1'b0;
    end else if (start_ok) begin
      consec_q <= win_done ? 3'h1 : consec_q + 3'h1;
      limit_q  <= (win_done ? 3'h1 : consec_q + 3'h1) >= i_cfg.max_consecutive;
    end else if (win_done) begin
      consec_q <= '0;
      limit_q  <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_sequence_active   <= 1'b0;
      o_limit_reached     <= 1'b0;
      o_consecutive_count <= '0;
    end else begin
      o_sequence_active   <= (state_q != S_IDLE);
      o_limit_reached     <= limit_q;
      o_consecutive_count <= consec_q;
    end
  end

  // ----------------------------------------------------------------
  // Parameter bank selection
  // ----------------------------------------------------------------
  logic       sel_level;
  accel_set_s bank2_accel_eff;
  decel_set_s bank2_decel_eff;

  always_comb begin
    case (i_bank_select_source)
      SRC_INPUT:   sel_level = i_digital_input_n;
      SRC_CMD_BIT: sel_level = i_command_word_bit;
      default:     sel_level = 1'b0;
    endcase
  end

  always_comb begin
    bank2_accel_eff = i_bank2_accel;
    bank2_decel_eff = i_bank2_decel;
    bank2_decel_eff.stop_type = i_basic_stop_type;
    if (i_usage == USE_DUAL_LOAD) begin
      bank2_accel_eff.nom_current = i_bank1_accel.nom_current;
      bank2_accel_eff.nom_speed   = i_bank1_accel.nom_speed;
      bank2_accel_eff.nom_power   = i_bank1_accel.nom_power;
    end else begin
      bank2_decel_eff.stop_type   = i_bank1_decel.stop_type;
      bank2_decel_eff.brake_time  = i_bank1_decel.brake_time;
      bank2_decel_eff.brake_level = i_bank1_decel.brake_level;
    end
  end

  // The active sets only take the selection at ramp starts, since the partner may not
  // switch mid-run; a change while running waits for the next ramp.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_active_accel <= '0;
    end else if (i_accel_start) begin
      o_active_accel <= sel_level ? bank2_accel_eff : i_bank1_accel;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_active_decel <= '0;
    end else if (i_decel_start) begin
      o_active_decel <= sel_level ? bank2_decel_eff : i_bank1_decel;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_bank2_selected <= 1'b0;
    end else begin
      o_bank2_selected <= sel_level;
    end
  end

endmodule // antijam_bank_ctrl

// file: logic/antijam_pkg.sv
// What this block does
// - Forward and reverse steps last configured seconds
// - Each step uses selectable force preset
// - Pause between forward and reverse steps
// - Stop after each step in halt style
// - Deceleration stop only with start profile
// - Sequence repeats configured forward-reverse cycles
// - Count consecutive sequences up to maximum
// - Consecutive count cleared at power-up
// - Sequence within window counts as consecutive
// - Zero window disables consecutive monitoring
// - Bank source: unassigned, digital input, command bit
// - Select low gives bank one, high bank two
// - Acceleration parameters switch at next acceleration
// - Deceleration parameters switch at next deceleration
// - Usage picks dual-load or two-speed, default two-speed
// - Dual-load forces nominal current, speed, power
// - Two-speed forces stop type, braking time, level
// - Basic stop type also applies to bank two in dual-load
package antijam_pkg;

  localparam int unsigned CLK_HZ            = 200_000_000;
  localparam int unsigned TICK_MS           = 1000;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0]  REV_SEC_RST       = 8'h05;
  localparam logic [7:0]  FWD_SEC_RST       = 8'h05;
  localparam logic [8:0]  PAUSE_SEC_RST     = 9'h002;
  localparam logic [3:0]  CYCLES_RST        = 4'h3;
  localparam logic [2:0]  MAX_SEQ_RST       = 3'h2;
  localparam logic [11:0] WINDOW_SEC_RST    = 12'h078;

  typedef enum logic [1:0] {FORCE_PROFILE, FORCE_LOW, FORCE_VERY_LOW} force_e;
  typedef enum logic       {HALT_FREEWHEEL, HALT_DECEL} halt_e;
  typedef enum logic [1:0] {SRC_NONE, SRC_INPUT, SRC_CMD_BIT} source_e;
  typedef enum logic       {USE_DUAL_LOAD, USE_TWO_SPEED} usage_e;

  typedef struct packed {
    logic [7:0]  reverse_duration;
    logic [7:0]  forward_duration;
    logic [8:0]  pause_time;
    halt_e       halt_style;
    force_e      forward_force;
    force_e      reverse_force;
    logic [3:0]  cycle_count;
    logic [2:0]  max_consecutive;
    logic [11:0] consecutive_window;
  } antijam_cfg_s;

  typedef struct packed {
    logic [15:0] current_limit;
    logic [15:0] torque_limit;
    logic [15:0] nom_current;
    logic [15:0] accel;
    logic [15:0] init_torque;
    logic [15:0] nom_power;
    logic [15:0] nom_speed;
  } accel_set_s;

  typedef struct packed {
    logic [1:0]  stop_type;
    logic [15:0] decel;
    logic [15:0] decel_gain;
    logic [15:0] freewheel_level;
    logic [15:0] brake_time;
    logic [15:0] brake_level;
  } decel_set_s;

  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    force_e drive_force;
    logic decel_stop;
  } motor_cmd_s;

endpackage : antijam_pkg

// file: logic/sec_timer.sv
// Seconds countdown; loads on start, raises done when it reaches zero.
module sec_timer
  import antijam_pkg::*;
#(
  parameter int unsigned W = 12
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_srst,
  input  wire logic         i_tick,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output logic              o_done,
  output logic [W-1:0]      o_count
);

  logic [W-1:0] count_q;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      count_q <= '0;
    end else if (i_load) begin
      count_q <= i_value;
    end else if (i_tick && count_q != '0) begin
      count_q <= count_q - W'(1);
    end
  end

  // Done looks only at the count: the load is steered by done, so a term on
  // the load here would close a combinational loop through the caller
  assign o_done  = (count_q == '0);
  assign o_count = count_q;

endmodule // sec_timer

// file: dv/antijam_chk.sv
// ----------------------------------------
// Checker on the sequencer and bank ports
// ----------------------------------------
module antijam_chk
  import antijam_pkg::*;
(
  input wire logic         i_core_clk,
  input wire logic         i_srst,
  input wire antijam_cfg_s i_cfg,
  input wire logic         i_antijam_request,
  input wire motor_cmd_s   o_motor_cmd,
  input wire logic         o_sequence_active,
  input wire logic         o_limit_reached,
  input wire logic [2:0]   o_consecutive_count,
  input wire source_e      i_bank_select_source,
  input wire logic         i_digital_input_n,
  input wire logic         i_command_word_bit,
  input wire usage_e       i_usage,
  input wire logic         i_accel_start,
  input wire logic         i_decel_start,
  input wire accel_set_s   i_bank1_accel,
  input wire decel_set_s   i_bank1_decel,
  input wire accel_set_s   i_bank2_accel,
  input wire decel_set_s   i_bank2_decel,
  input wire logic [1:0]   i_basic_stop_type,
  input wire accel_set_s   o_active_accel,
  input wire decel_set_s   o_active_decel,
  input wire logic         o_bank2_selected
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sel_lvl;
  logic       mon_on;
  accel_set_s exp_acc;
  decel_set_s exp_dec;

  assign mon_on  = i_cfg.consecutive_window != 12'h000;
  assign sel_lvl = (i_bank_select_source == SRC_INPUT && i_digital_input_n) ||
                   (i_bank_select_source == SRC_CMD_BIT && i_command_word_bit);

  // Forced fields follow bank one, or the basic stop type in dual-load, so a stale copy in bank two stays hidden
  always_comb begin
    exp_acc = sel_lvl ? i_bank2_accel : i_bank1_accel;
    exp_dec = sel_lvl ? i_bank2_decel : i_bank1_decel;
    if (sel_lvl && i_usage == USE_DUAL_LOAD) begin
      exp_acc.nom_current = i_bank1_accel.nom_current;
      exp_acc.nom_power   = i_bank1_accel.nom_power;
      exp_acc.nom_speed   = i_bank1_accel.nom_speed;
      exp_dec.stop_type   = i_basic_stop_type;
    end
    if (sel_lvl && i_usage == USE_TWO_SPEED) begin
      exp_dec.stop_type   = i_bank1_decel.stop_type;
      exp_dec.brake_time  = i_bank1_decel.brake_time;
      exp_dec.brake_level = i_bank1_decel.brake_level;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  sequence seq_start;
    !o_sequence_active ##1 o_sequence_active;
  endsequence

  one_direction_a: assert property (!(o_motor_cmd.run_fwd && o_motor_cmd.run_rev))
    else $error("forward and reverse driven together");
  start_forward_a: assert property (seq_start |-> o_motor_cmd.run_fwd && $past(i_antijam_request, 2))
    else $error("sequence start without request or forward step");
  refuse_limit_a: assert property (seq_start |-> !($past(o_limit_reached) && mon_on))
    else $error("sequence started while limited");
  count_bound_a: assert property (mon_on |-> o_consecutive_count <= i_cfg.max_consecutive)
    else $error("consecutive count above maximum");
  limit_flag_a: assert property (mon_on && o_consecutive_count >= i_cfg.max_consecutive &&
    o_consecutive_count != 3'h0 |-> ##[0:1] o_limit_reached)
    else $error("limit not flagged at maximum");
  halt_style_a: assert property (o_motor_cmd.decel_stop |-> i_cfg.halt_style == HALT_DECEL)
    else $error("controlled stop in freewheel style");
  fwd_force_a: assert property (o_motor_cmd.run_fwd |-> o_motor_cmd.drive_force == i_cfg.forward_force)
    else $error("forward step force wrong");
  rev_force_a: assert property (o_motor_cmd.run_rev |-> o_motor_cmd.drive_force == i_cfg.reverse_force)
    else $error("reverse step force wrong");
  select_follow_a: assert property (1'b1 |=> o_bank2_selected == $past(sel_lvl))
    else $error("bank select level wrong");
  accel_latch_a: assert property (i_accel_start |=> o_active_accel == $past(exp_acc))
    else $error("acceleration set latched wrong");
  accel_hold_a: assert property (!i_accel_start |=> $stable(o_active_accel))
    else $error("acceleration set moved without start");
  decel_latch_a: assert property (i_decel_start |=> o_active_decel == $past(exp_dec))
    else $error("deceleration set latched wrong");
  decel_hold_a: assert property (!i_decel_start |=> $stable(o_active_decel))
    else $error("deceleration set moved without start");
endmodule // antijam_chk

bind antijam_bank_ctrl antijam_chk i_antijam_chk (.*);

// file: dv/select_source_model.sv
// ----------------------------------------
// Input or command word source
// ----------------------------------------
module select_source_model (
  input  wire logic i_core_clk,
  input  wire logic i_standstill,
  input  wire logic i_want_input,
  input  wire logic i_want_bit,
  output logic      o_digital_input_n,
  output logic      o_command_word_bit
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_digital_input_n  = 1'b0;
    o_command_word_bit = 1'b0;
  end
  // A change asked for while running waits until the motor stands still
  always @(posedge i_core_clk) begin
    if (i_standstill) begin
      o_digital_input_n  <= i_want_input;
      o_command_word_bit <= i_want_bit;
    end
  end
endmodule // select_source_model

// file: dv/testbench.sv
module testbench
  import antijam_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk, srst, req, di_w, cmd_w, acc_st, dec_st, di, cmdb, act, lim, b2sel, sel;
  logic [1:0]   basic;
  logic [2:0]   cnt;
  antijam_cfg_s cfg;
  source_e      src;
  usage_e       usage;
  motor_cmd_s   mcmd;
  accel_set_s   b1a, b2a, aacc, ea;
  decel_set_s   b1d, b2d, adec, ed;
  int           error_cnt, n_compared;

  antijam_bank_ctrl i_antijam_bank_ctrl (.i_core_clk(clk), .i_srst(srst), .i_cfg(cfg),
    .i_antijam_request(req), .o_motor_cmd(mcmd), .o_sequence_active(act), .o_limit_reached(lim),
    .o_consecutive_count(cnt), .i_bank_select_source(src), .i_digital_input_n(di),
    .i_command_word_bit(cmdb), .i_usage(usage), .i_accel_start(acc_st), .i_decel_start(dec_st),
    .i_bank1_accel(b1a), .i_bank1_decel(b1d), .i_bank2_accel(b2a), .i_bank2_decel(b2d),
    .i_basic_stop_type(basic), .o_active_accel(aacc), .o_active_decel(adec), .o_bank2_selected(b2sel));
  select_source_model i_select_source_model (.i_core_clk(clk), .i_standstill(!act), .i_want_input(di_w),
    .i_want_bit(cmd_w), .o_digital_input_n(di), .o_command_word_bit(cmdb));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Counts step starts and controlled stops over one requested sequence
  task automatic run_seq(input logic [3:0] n_exp);
    int   nf, nr, nd, bad, t;
    logic pf, pr, lastf;
    nf = 0; nr = 0; nd = 0; bad = 0; pf = 0; pr = 0; lastf = 0;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    for (t = 0; t < 600; t++) begin
      @(negedge clk);
      if (mcmd.run_fwd === 1'b1 && pf !== 1'b1) nf++;
      if (mcmd.run_rev === 1'b1 && pr !== 1'b1) nr++;
      if (mcmd.run_fwd === 1'b1) lastf = 1'b1;
      if (mcmd.run_rev === 1'b1) lastf = 1'b0;
      if (mcmd.decel_stop === 1'b1 && lastf) bad++;
      if (mcmd.decel_stop === 1'b1 && !lastf) nd++;
      pf = mcmd.run_fwd;
      pr = mcmd.run_rev;
      if (act !== 1'b1 && t > 3) break;
    end
    if (t == 600) begin
      error_cnt++;
      results();
    end
    check(nf, n_exp);
    check(nr, n_exp);
    check(bad, 0);
    check(nd != 0, n_exp != 0 && cfg.halt_style == HALT_DECEL);
  endtask

  initial begin
    {srst, req, di_w, cmd_w, acc_st, dec_st} = 6'h20;
    cfg   = '{8'h00, 8'h00, 9'h000, HALT_DECEL, FORCE_VERY_LOW, FORCE_PROFILE, 4'h3, 3'h2, 12'h005};
    src   = SRC_NONE;
    usage = USE_TWO_SPEED;
    basic = 2'h3;
    b1a   = {7{16'h1111}};
    b2a   = {7{16'h2222}};
    b1d   = {2'h1, {5{16'h3333}}};
    b2d   = {2'h2, {5{16'h4444}}};
    repeat (12) @(negedge clk);
    srst = 1'b0;
    check(cnt, 3'h0);
    check(mcmd, {2'b00, FORCE_LOW, 1'b0});
    run_seq(4'h3);
    check({lim, cnt}, 4'h1);
    run_seq(4'h3);
    check({lim, cnt}, 4'ha);
    run_seq(4'h0);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    check({lim, cnt}, 4'h0);
    cfg = '{8'h00, 8'h00, 9'h000, HALT_FREEWHEEL, FORCE_PROFILE, FORCE_LOW, 4'ha, 3'h1, 12'h000};
    repeat (3) run_seq(4'ha);
    check({lim, cnt}, 4'h0);
    ea = '0;
    ed = '0;
    for (int k = 0; k < 12; k++) begin
      src   = source_e'(k % 3);
      usage = usage_e'(k / 6);
      di_w  = (k / 3) % 2;
      cmd_w = !di_w;
      sel   = (src == SRC_INPUT) ? di_w : (src == SRC_CMD_BIT) && cmd_w;
      repeat (3) @(negedge clk);
      check(b2sel, sel);
      check(aacc, ea);
      acc_st = 1'b1;
      @(negedge clk);
      acc_st = 1'b0;
      @(negedge clk);
      ea = sel ? b2a : b1a;
      check(adec, ed);
      ed = sel ? b2d : b1d;
      if (sel && usage == USE_DUAL_LOAD) begin
        ea.nom_current = b1a.nom_current;
        ea.nom_power   = b1a.nom_power;
        ea.nom_speed   = b1a.nom_speed;
        ed.stop_type   = basic;
      end
      if (sel && usage == USE_TWO_SPEED) begin
        ed.stop_type   = b1d.stop_type;
        ed.brake_time  = b1d.brake_time;
        ed.brake_level = b1d.brake_level;
      end
      check(aacc, ea);
      dec_st = 1'b1;
      @(negedge clk);
      dec_st = 1'b0;
      @(negedge clk);
      check(adec, ed);
    end
    results();
  end
endmodule // testbench
